// >>> design/vosc_regs.sv
// register slice for output format, output clock, sync routing, sync filter and power control
//
// Function
// RULE1 - power control bit 2 picks sleep pin polarity, 0 active low, default 0
// RULE2 - fast switching bit keeps chip powered, sleep only tristates outputs
// RULE3 - power bit 0 tristates green sync output during power-down when set
// RULE4 - output select 1 bits 7:5 pick format, 100 default RGB, 101, 110
// RULE5 - output select 1 bit 4 enables primary port, default on
// RULE6 - output select 1 bit 3 enables secondary port, default off
// RULE7 - bits 2:1 drive strength except frame sync, 00 low, 01 med, 1x high
// RULE8 - output select 1 bit 0 inverts output data clock
// RULE9 - output select 2 bits 7:6 pick pixel, 90 degree, double or half clock
// RULE10 - output select 2 bit 5 tristates every output except green sync
// RULE11 - output select 2 bit 4 tristates green sync output unconditionally
// RULE12 - output select 2 bit 3 swaps field output polarity
// RULE13 - output select 2 bit 2 feeds loop filtered sync, else raw sync
// RULE14 - output select 2 bit 1 feeds sync processor regenerated sync, else raw
// RULE15 - software must write 1 to output select 2 bit 0
// RULE16 - software keeps the two fixed settings at their reset values
// RULE17 - sync filter passes pulses in window around regenerated edge, 25 ns steps; code rounds a step up to 4 cycles of 8 ns, 32 ns
// RULE18 - status bit 7 reads 1 while line sync input zero is active
// RULE19 - power bit 4 selects auto pin control, else bit 3 powers down manually
// RULE20 - writes to the status register are ignored, bits show live activity
`timescale 1ns/1ps

module vosc_regs
  import vosc_pkg::*;
#(
  parameter int ACT_TIMEOUT_CYC = VOSC_ACT_TIMEOUT_CYC,
  parameter int PERIOD_W        = 16
)
(
  // clock, reset, enable
  input  wire logic          ref_clk_in,
  input  wire logic          reset_in,
  input  wire logic          clk_en_in,
  // register port
  input  wire logic [7:0]    reg_addr_in,
  input  wire logic [7:0]    reg_wdata_in,
  input  wire logic          reg_wr_in,
  input  wire logic          reg_rd_in,
  output logic      [7:0]    reg_rdata_out,
  // pins and sync sources
  input  wire logic          sleep_pin_in,
  input  wire logic          line_sync_input_zero_in,
  input  wire logic          raw_sync_in,
  input  wire logic          regen_line_sync_in,
  input  wire logic          field_odd_in,
  // configuration and control outputs
  output vosc_out_cfg_t      out_cfg_out,
  output vosc_oe_t           oe_out,
  output logic               chip_powerdown_out,
  output logic               field_out,
  output logic               pll_sync_out,
  output logic               sync_proc_out,
  output logic               filtered_sync_out
);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0]          pwr_r;
  logic [7:0]          os1_r;
  logic [7:0]          os2_r;
  logic [7:0]          fixed_a_r;
  logic [7:0]          fixed_b_r;
  logic [7:0]          window_r;
  logic                ls0_active_r;
  logic                ls0_prev_r;
  logic [PERIOD_W-1:0] act_cnt_r;
  logic                regen_prev_r;
  logic [PERIOD_W-1:0] since_edge_r;
  logic [PERIOD_W-1:0] period_r;
  logic                period_ok_r;

  // decode of a write to one offset
  function automatic logic wr_hit(input logic [7:0] ofs);
    wr_hit = reg_wr_in && (reg_addr_in == ofs);
  endfunction

  // software writes; fixed settings kept writable so software can restore them
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      pwr_r     <= VOSC_RST_PWR;
      os1_r     <= VOSC_RST_OUTSEL1;
      os2_r     <= VOSC_RST_OUTSEL2;
      fixed_a_r <= VOSC_RST_FIXED_A;
      fixed_b_r <= VOSC_RST_FIXED_B;
      window_r  <= VOSC_RST_WINDOW;
    end
    else if (clk_en_in)
    begin
      if (wr_hit(VOSC_OFS_PWR))
        pwr_r <= reg_wdata_in;
      if (wr_hit(VOSC_OFS_OUTSEL1))
        os1_r <= reg_wdata_in;
      if (wr_hit(VOSC_OFS_OUTSEL2))
        os2_r <= reg_wdata_in;    // RULE15
      if (wr_hit(VOSC_OFS_FIXED_A))
        fixed_a_r <= reg_wdata_in; // RULE16
      if (wr_hit(VOSC_OFS_FIXED_B))
        fixed_b_r <= reg_wdata_in; // RULE16
      if (wr_hit(VOSC_OFS_WINDOW))
        window_r <= reg_wdata_in;
    end
  end

  // read data one cycle after the strobe, zero elsewhere and on unmapped offsets
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
      reg_rdata_out <= 8'h00;
    else if (clk_en_in)
    begin
      reg_rdata_out <= 8'h00;
      if (reg_rd_in)
      begin
        case (reg_addr_in)
          VOSC_OFS_PWR:     reg_rdata_out <= pwr_r;
          VOSC_OFS_OUTSEL1: reg_rdata_out <= os1_r;
          VOSC_OFS_OUTSEL2: reg_rdata_out <= os2_r;
          VOSC_OFS_FIXED_A: reg_rdata_out <= fixed_a_r;
          VOSC_OFS_FIXED_B: reg_rdata_out <= fixed_b_r;
          VOSC_OFS_WINDOW:  reg_rdata_out <= window_r;
          VOSC_OFS_STATUS:  reg_rdata_out <= {ls0_active_r, 7'h00}; // RULE20
          default:          reg_rdata_out <= 8'h00;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line sync zero activity: any edge restarts a timeout, expiry means inactive

  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      ls0_prev_r   <= 1'b0;
      act_cnt_r    <= '0;
      ls0_active_r <= 1'b0;
    end
    else if (clk_en_in)
    begin
      ls0_prev_r <= line_sync_input_zero_in;
      if (line_sync_input_zero_in != ls0_prev_r)
      begin
        act_cnt_r    <= '0;
        ls0_active_r <= 1'b1;                                    // RULE18
      end
      else if (act_cnt_r >= PERIOD_W'(ACT_TIMEOUT_CYC - 1))
        ls0_active_r <= 1'b0;                                    // RULE18
      else
        act_cnt_r <= act_cnt_r + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sync filter: learn the line period from regenerated edges, open a window
  // of half the width either side of the expected edge; an unlearnt period
  // only opens after the edge, since nothing can be predicted yet

  logic                regen_rise;
  logic [PERIOD_W-1:0] half_win;
  logic [PERIOD_W-1:0] to_edge;
  logic                in_window;

  assign regen_rise = regen_line_sync_in && !regen_prev_r;
  assign half_win   = PERIOD_W'((32'(window_r) * 32'(VOSC_WIN_STEP_CYC)) >> 1); // RULE17
  assign to_edge    = period_r - since_edge_r;
  assign in_window  = (since_edge_r < half_win) || (period_ok_r && (to_edge <= half_win)); // RULE17

  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      regen_prev_r <= 1'b0;
      since_edge_r <= '0;
      period_r     <= '0;
      period_ok_r  <= 1'b0;
    end
    else if (clk_en_in)
    begin
      regen_prev_r <= regen_line_sync_in;
      if (regen_rise)
      begin
        period_r     <= since_edge_r;
        period_ok_r  <= (since_edge_r != '1);
        since_edge_r <= '0;
      end
      else if (since_edge_r != '1)
        since_edge_r <= since_edge_r + 1'b1;
      else
        period_ok_r <= 1'b0; // edges lost, stop predicting
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-down and output enables

  logic pin_asserted;
  logic pd_request;
  logic pd_tristate;
  logic filtered_sync;

  assign pin_asserted  = pwr_r[VOSC_PWR_PINPOL_BIT] ? sleep_pin_in : !sleep_pin_in;   // RULE1
  assign pd_request    = pwr_r[VOSC_PWR_AUTO_BIT] ? pin_asserted
                                                  : pwr_r[VOSC_PWR_MANUAL_BIT];       // RULE19
  assign pd_tristate   = pd_request;                                                 // RULE2
  assign filtered_sync = raw_sync_in && in_window;                                   // RULE17

  // drive strength decode, upper bit set means high whatever the low bit
  function automatic vosc_drive_t drive_decode(input logic [1:0] code);
    if (code[1])
      drive_decode = VOSC_DRV_HIGH;   // RULE7
    else if (code[0])
      drive_decode = VOSC_DRV_MED;    // RULE7
    else
      drive_decode = VOSC_DRV_LOW;    // RULE7
  endfunction

  // registered outputs so pins never see decode glitches
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      out_cfg_out        <= '0;
      oe_out             <= '0;
      chip_powerdown_out <= 1'b0;
      field_out          <= 1'b0;
      pll_sync_out       <= 1'b0;
      sync_proc_out      <= 1'b0;
      filtered_sync_out  <= 1'b0;
    end
    else if (clk_en_in)
    begin
      out_cfg_out.format     <= os1_r[VOSC_OS1_FMT_LSB +: 3];                      // RULE4
      out_cfg_out.drive      <= drive_decode(os1_r[VOSC_OS1_DRV_LSB +: 2]);        // RULE7
      out_cfg_out.clk_sel    <= vosc_cksel_t'(os2_r[VOSC_OS2_CKSEL_LSB +: 2]);     // RULE9
      out_cfg_out.clk_invert <= os1_r[VOSC_OS1_CKINV_BIT];                         // RULE8
      chip_powerdown_out     <= pd_request && !pwr_r[VOSC_PWR_FAST_BIT];           // RULE2
      oe_out.primary    <= os1_r[VOSC_OS1_PRI_BIT] && !os2_r[VOSC_OS2_ALLHIZ_BIT] && !pd_tristate; // RULE5
      oe_out.secondary  <= os1_r[VOSC_OS1_SEC_BIT] && !os2_r[VOSC_OS2_ALLHIZ_BIT] && !pd_tristate; // RULE6
      oe_out.frame_sync <= !os2_r[VOSC_OS2_ALLHIZ_BIT] && !pd_tristate;            // RULE10
      oe_out.data_clock <= !os2_r[VOSC_OS2_ALLHIZ_BIT] && !pd_tristate;            // RULE10
      oe_out.green_sync <= !os2_r[VOSC_OS2_GSHIZ_BIT]                              // RULE11
                           && !(pd_request && pwr_r[VOSC_PWR_GSHIZ_BIT]);           // RULE3
      field_out         <= field_odd_in ^ os2_r[VOSC_OS2_FLDPOL_BIT];              // RULE12
      pll_sync_out      <= os2_r[VOSC_OS2_PLLFLT_BIT] ? filtered_sync : raw_sync_in;        // RULE13
      sync_proc_out     <= os2_r[VOSC_OS2_SPSRC_BIT] ? regen_line_sync_in : raw_sync_in;    // RULE14
      filtered_sync_out <= filtered_sync;
    end
  end

endmodule // vosc_regs

// >>> include/vosc_pkg.sv
// package for the video output, sync route and power configuration register slice
package vosc_pkg;

  // register offsets
  localparam logic [7:0] VOSC_OFS_PWR     = 8'h1E;
  localparam logic [7:0] VOSC_OFS_OUTSEL1 = 8'h1F;
  localparam logic [7:0] VOSC_OFS_OUTSEL2 = 8'h20;
  localparam logic [7:0] VOSC_OFS_FIXED_A = 8'h21;
  localparam logic [7:0] VOSC_OFS_FIXED_B = 8'h22;
  localparam logic [7:0] VOSC_OFS_WINDOW  = 8'h23;
  localparam logic [7:0] VOSC_OFS_STATUS  = 8'h24;

  // reset values
  localparam logic [7:0] VOSC_RST_PWR     = 8'h30;
  localparam logic [7:0] VOSC_RST_OUTSEL1 = 8'h94;
  localparam logic [7:0] VOSC_RST_OUTSEL2 = 8'h04;
  localparam logic [7:0] VOSC_RST_FIXED_A = 8'h20;
  localparam logic [7:0] VOSC_RST_FIXED_B = 8'h32;
  localparam logic [7:0] VOSC_RST_WINDOW  = 8'h0A;

  // power control fields
  localparam int VOSC_PWR_AUTO_BIT   = 4;
  localparam int VOSC_PWR_MANUAL_BIT = 3;
  localparam int VOSC_PWR_PINPOL_BIT = 2;
  localparam int VOSC_PWR_FAST_BIT   = 1;
  localparam int VOSC_PWR_GSHIZ_BIT  = 0;

  // output select 1 fields
  localparam int VOSC_OS1_FMT_LSB   = 5;
  localparam int VOSC_OS1_PRI_BIT   = 4;
  localparam int VOSC_OS1_SEC_BIT   = 3;
  localparam int VOSC_OS1_DRV_LSB   = 1;
  localparam int VOSC_OS1_CKINV_BIT = 0;

  // output select 2 fields
  localparam int VOSC_OS2_CKSEL_LSB  = 6;
  localparam int VOSC_OS2_ALLHIZ_BIT = 5;
  localparam int VOSC_OS2_GSHIZ_BIT  = 4;
  localparam int VOSC_OS2_FLDPOL_BIT = 3;
  localparam int VOSC_OS2_PLLFLT_BIT = 2;
  localparam int VOSC_OS2_SPSRC_BIT  = 1;

  // status fields
  localparam int VOSC_ST_LS0_BIT = 7;

  // timing: window step and default activity timeout
  localparam int VOSC_CLK_PERIOD_PS   = 8000;
  localparam int VOSC_WIN_STEP_NS     = 25;
  localparam int VOSC_WIN_STEP_CYC    = (VOSC_WIN_STEP_NS * 1000 + VOSC_CLK_PERIOD_PS - 1) / VOSC_CLK_PERIOD_PS;
  localparam int VOSC_ACT_TIMEOUT_CYC = 65536;

  // output format codes
  typedef enum logic [2:0]
  {
    VOSC_FMT_RGB444 = 3'h4,
    VOSC_FMT_YC422  = 3'h5,
    VOSC_FMT_DDR444 = 3'h6
  } vosc_fmt_t;

  // decoded drive strength
  typedef enum logic [1:0]
  {
    VOSC_DRV_LOW,
    VOSC_DRV_MED,
    VOSC_DRV_HIGH
  } vosc_drive_t;

  // output clock selection
  typedef enum logic [1:0]
  {
    VOSC_CK_PIXEL,
    VOSC_CK_PHASE90,
    VOSC_CK_DOUBLE,
    VOSC_CK_HALF
  } vosc_cksel_t;

  // configuration carried to the output formatter and clock path
  typedef struct packed
  {
    logic [2:0]  format;
    vosc_drive_t drive;
    vosc_cksel_t clk_sel;
    logic        clk_invert;
  } vosc_out_cfg_t;

  // output enables of the pin groups
  typedef struct packed
  {
    logic primary;
    logic secondary;
    logic frame_sync;
    logic data_clock;
    logic green_sync;
  } vosc_oe_t;

endpackage

// >>> verification/tb_top.sv
// self-checking bench for the output and sync configuration slice
`timescale 1ns/1ps

module tb_top;
  import vosc_pkg::*;
  // design ports
  logic          ref_clk_in, reset_in, clk_en_in, reg_wr_in, reg_rd_in, sleep_pin_in;
  logic          ls0_in, raw_sync_in, regen_in, field_odd_in, pd_out, field_out, pll_out, sproc_out, filt_out;
  logic [7:0]    reg_addr_in, reg_wdata_in, reg_rdata_out, rd_val;
  vosc_out_cfg_t out_cfg_out, cfg_exp;
  vosc_oe_t      oe_out;
  // bookkeeping: reset table, power table {reg, pin, powerdown, enables}
  int            bad_count, samples_checked, cycles, half_cyc;
  logic [7:0]    rst_tab [7] = '{8'h30, 8'h94, 8'h04, 8'h20, 8'h32, 8'h0A, 8'h00};
  logic [14:0]   pw_tab [8] = '{{8'h30, 7'h21}, {8'h30, 7'h57}, {8'h34, 7'h17}, {8'h34, 7'h61},
                                {8'h32, 7'h01}, {8'h31, 7'h20}, {8'h08, 7'h61}, {8'h00, 7'h57}};

  vosc_regs #(.ACT_TIMEOUT_CYC(64)) u_vosc_regs (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .clk_en_in(clk_en_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .sleep_pin_in(sleep_pin_in),
    .line_sync_input_zero_in(ls0_in), .raw_sync_in(raw_sync_in), .regen_line_sync_in(regen_in),
    .field_odd_in(field_odd_in), .out_cfg_out(out_cfg_out), .oe_out(oe_out), .chip_powerdown_out(pd_out),
    .field_out(field_out), .pll_sync_out(pll_out), .sync_proc_out(sproc_out), .filtered_sync_out(filt_out));

  ////////////////////////////////////////////////////////////
  // bus tasks: strobes one cycle, changed just after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_in    <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_in   <= 1'b0;
    #1;
    rd_val = reg_rdata_out;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t ns: got 0x%h expected 0x%h", $time, got, exp);
    end
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    chk(rd_val, exp);
  endtask
  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // clock, and a hang limit well above the expected run
  initial
  begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      bad_count++;
      end_of_test();
    end
  end

  // main sequence
  initial
  begin
    {reset_in, sleep_pin_in, clk_en_in} = 3'h7;
    {reg_wr_in, reg_rd_in, ls0_in, raw_sync_in, regen_in, field_odd_in} = 6'h00;
    reg_addr_in = 8'h00;
    reg_wdata_in = 8'h00;
    repeat (12) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    for (int i = 0; i < 7; i++)
      chk_rd(VOSC_OFS_PWR + 8'(i), rst_tab[i]);
    chk(out_cfg_out, 8'h90);
    chk({3'h0, oe_out}, 8'h17);
    wr(VOSC_OFS_STATUS, 8'hFF);
    chk_rd(VOSC_OFS_STATUS, 8'h00);
    chk_rd(8'h25, 8'h00);
    $display("reset and status test done");
    // every format, drive and clock code, with readback
    for (int j = 0; j < 4; j++)
    begin
      wr(VOSC_OFS_OUTSEL1, {3'(4 + j % 3), 1'b1, j[0], j[1:0], j[0]});
      wr(VOSC_OFS_OUTSEL2, {j[1:0], 6'h05});
      tick(1);
      cfg_exp.format = 3'(4 + j % 3);
      cfg_exp.drive = j[1] ? VOSC_DRV_HIGH : (j[0] ? VOSC_DRV_MED : VOSC_DRV_LOW);
      cfg_exp.clk_sel = vosc_cksel_t'(j[1:0]);
      cfg_exp.clk_invert = j[0];
      chk(out_cfg_out, cfg_exp);
      chk({3'h0, oe_out}, {4'h1, j[0], 3'h7});
      chk_rd(VOSC_OFS_OUTSEL2, {j[1:0], 6'h05});
    end
    wr(VOSC_OFS_OUTSEL1, VOSC_RST_OUTSEL1);
    wr(VOSC_OFS_OUTSEL2, 8'h25);
    tick(1);
    chk({3'h0, oe_out}, 8'h01);
    wr(VOSC_OFS_OUTSEL2, 8'h15);
    tick(1);
    chk({3'h0, oe_out}, 8'h16);
    $display("format and enable test done");
    // field polarity, raw loop source and sync processor source
    for (int k = 0; k < 4; k++)
    begin
      @(posedge ref_clk_in);
      field_odd_in <= k[1];
      raw_sync_in <= k[0];
      regen_in <= ~k[0];
      wr(VOSC_OFS_OUTSEL2, {4'h0, k[0], 1'b0, k[1], 1'b1});
      tick(1);
      chk({field_out, pll_out, sproc_out}, {k[1] ^ k[0], k[0], k[1] ? ~k[0] : k[0]});
    end
    $display("routing test done");
    // pin polarity, fast switching, green sync tristate, manual mode
    for (int p = 0; p < 8; p++)
    begin
      @(posedge ref_clk_in);
      sleep_pin_in <= pw_tab[p][6];
      wr(VOSC_OFS_PWR, pw_tab[p][14:7]);
      tick(1);
      chk({pd_out, oe_out}, {2'h0, pw_tab[p][5:0]});
    end
    $display("power test done");
    // a write with the enable low is lost; storage of a window value, fixed B still at its reset value
    @(posedge ref_clk_in);
    clk_en_in <= 1'b0;
    wr(VOSC_OFS_WINDOW, 8'h55);
    clk_en_in <= 1'b1;
    chk_rd(VOSC_OFS_WINDOW, VOSC_RST_WINDOW);
    wr(VOSC_OFS_WINDOW, 8'hFF);
    chk_rd(VOSC_OFS_WINDOW, 8'hFF);
    chk_rd(VOSC_OFS_FIXED_B, VOSC_RST_FIXED_B);
    // line sync activity shows in the status, then times out
    for (int s = 0; s < 6; s++)
      @(posedge ref_clk_in) ls0_in <= ~ls0_in;
    rd(VOSC_OFS_STATUS);
    chk(rd_val & 8'h80, 8'h80);
    tick(80);
    rd(VOSC_OFS_STATUS);
    chk(rd_val & 8'h80, 8'h00);
    $display("storage and status test done");
    // raw sync reaches the loop only inside the window after a regenerated edge
    half_cyc = (5 * VOSC_WIN_STEP_CYC) / 2;
    wr(VOSC_OFS_WINDOW, 8'h05);
    wr(VOSC_OFS_OUTSEL2, 8'h05);
    @(posedge ref_clk_in);
    raw_sync_in <= 1'b1;
    tick(1);
    chk({6'h00, pll_out, filt_out}, 8'h00);
    @(posedge ref_clk_in);
    regen_in <= 1'b1;
    tick(2);
    chk({6'h00, pll_out, filt_out}, 8'h03);
    tick(half_cyc - 1);
    chk({6'h00, pll_out, filt_out}, 8'h03);
    tick(1);
    chk({6'h00, pll_out, filt_out}, 8'h00);
    $display("sync filter test done");
    // a reset in mid-run restores the reset values
    @(posedge ref_clk_in);
    reset_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    chk_rd(VOSC_OFS_WINDOW, VOSC_RST_WINDOW);
    chk_rd(VOSC_OFS_OUTSEL2, VOSC_RST_OUTSEL2);
    $display("mid-run reset test done");
    end_of_test();
  end
endmodule // tb_top

// >>> verification/vosc_regs_assertions.sv
// concurrent checks on the output and sync configuration slice
`timescale 1ns/1ps

module vosc_regs_assertions
  import vosc_pkg::*;
(
  // clock, reset and register port
  input wire logic          ref_clk_in,
  input wire logic          reset_in,
  input wire logic          clk_en_in,
  input wire logic [7:0]    reg_addr_in,
  input wire logic [7:0]    reg_wdata_in,
  input wire logic          reg_wr_in,
  // sync inputs and watched outputs
  input wire logic          field_odd_in,
  input wire logic          raw_sync_in,
  input wire logic          regen_line_sync_in,
  input wire vosc_out_cfg_t out_cfg_out,
  input wire vosc_oe_t      oe_out,
  input wire logic          chip_powerdown_out,
  input wire logic          field_out,
  input wire logic          sync_proc_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  ////////////////////////////////////////////////////////////
  // a write lands in the register, outputs follow one edge later
  a_format_follow: assert property (clk_en_in && reg_wr_in && reg_addr_in == VOSC_OFS_OUTSEL1 ##1 clk_en_in
    |=> out_cfg_out.format == $past(reg_wdata_in[7:5], 2) && out_cfg_out.clk_invert == $past(reg_wdata_in[0], 2))
    else $error("format or clock invert mismatch");
  a_drive_decode: assert property (clk_en_in && reg_wr_in && reg_addr_in == VOSC_OFS_OUTSEL1 ##1 clk_en_in
    |=> out_cfg_out.drive == ($past(reg_wdata_in[2], 2) ? VOSC_DRV_HIGH : $past(reg_wdata_in[1], 2) ? VOSC_DRV_MED
    : VOSC_DRV_LOW)) else $error("drive strength mismatch");
  a_clksel_follow: assert property (clk_en_in && reg_wr_in && reg_addr_in == VOSC_OFS_OUTSEL2 ##1 clk_en_in
    |=> out_cfg_out.clk_sel == $past(reg_wdata_in[7:6], 2)) else $error("clock select mismatch");
  a_hiz_bits: assert property (clk_en_in && reg_wr_in && reg_addr_in == VOSC_OFS_OUTSEL2 ##1 clk_en_in
    |=> (!$past(reg_wdata_in[4], 2) || !oe_out.green_sync) && (!$past(reg_wdata_in[5], 2) || !oe_out.primary))
    else $error("high impedance bit ignored");
  // polarity is constant without a write, so field toggles track input toggles
  a_field_track: assert property (clk_en_in && !reg_wr_in ##1 clk_en_in
    |=> (field_out ^ $past(field_out)) == ($past(field_odd_in, 2) ^ $past(field_odd_in)))
    else $error("field output does not track input");
  a_sproc_source: assert property (clk_en_in
    |=> sync_proc_out == $past(regen_line_sync_in) || sync_proc_out == $past(raw_sync_in))
    else $error("sync processor source unknown");
  a_pdown_tristate: assert property (chip_powerdown_out
    |-> !oe_out.primary && !oe_out.secondary && !oe_out.frame_sync && !oe_out.data_clock)
    else $error("outputs driven while powered down");
  a_status_wr_ign: assert property (clk_en_in && reg_wr_in && reg_addr_in == VOSC_OFS_STATUS
    |-> ##2 $stable(out_cfg_out)) else $error("status write altered configuration");
endmodule // vosc_regs_assertions

bind vosc_regs vosc_regs_assertions u_vosc_regs_assertions (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
  .clk_en_in(clk_en_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .field_odd_in(field_odd_in), .raw_sync_in(raw_sync_in), .regen_line_sync_in(regen_line_sync_in),
  .out_cfg_out(out_cfg_out), .oe_out(oe_out), .chip_powerdown_out(chip_powerdown_out), .field_out(field_out),
  .sync_proc_out(sync_proc_out));
